// *** design/status_indicator_and_watchdog.sv ***
// Overview of operation
// - Input LED red below 8 V, else green
// - Power LED dark in mechanical off
// - Power LED orange in soft off
// - Power LED green when working, not hot
// - Hot CPU blinks power LED green/orange
// - Critical heat forces soft off, blinks orange/red
// - Reset LED steady red during reset
// - Power failure blinks reset LED until unpowered
// - Activity LED: dark, green, blinking on traffic
// - Speed LED: dark 10M, green 100M, orange 1G
// - Watchdog tick selectable: 10 ms, 1 s, 1 min
// - Watchdog timeout spans 10 ms to 256 min
// - Watchdog expiry asserts full system reset
`timescale 1ns/10ps
`default_nettype none

module status_indicator_and_watchdog
  import status_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned NUM_LAN = 2
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Power and thermal status
  input wire logic i_vin_low,
  input wire logic [2:0] i_acpi_state,
  input wire logic i_cpu_hot,
  input wire logic i_cpu_crit,
  input wire logic i_sys_in_reset,
  input wire logic i_power_fail,
  // Ethernet ports
  input wire lan_t [NUM_LAN-1:0] i_lan,
  // Watchdog control
  input wire wdt_ctl_t i_wdt,
  // Front panel LEDs
  output led_t o_pwr_in_led,
  output led_t o_pwr_led,
  output led_t o_rst_led,
  // Ethernet LEDs
  output led_t [NUM_LAN-1:0] o_lan_act_led,
  output led_t [NUM_LAN-1:0] o_lan_spd_led,
  // System control and status
  output logic o_force_soft_off,
  output logic o_wdt_sys_reset,
  output logic [WDT_CNT_W-1:0] o_wdt_remaining
);

  //////////////////////////////////////////////////////////////////////////
  // Reset release and time base

  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  logic tick;

  tick_gen #(
    .CYCLES(TICK_CYC)
  ) u_tick (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n_q),
    .o_tick(tick)
  );

  // Wrapping counter step, shared by every divider stage
  function automatic logic [7:0] wrap_inc(input logic [7:0] v,
                                           input logic [7:0] last);
    wrap_inc = (v == last) ? 8'h00 : v + 8'h01;
  endfunction : wrap_inc

  // Alternate between two colours on the blink phase
  function automatic led_t blink2(input logic ph, input led_t a,
                                  input led_t b);
    blink2 = ph ? b : a;
  endfunction : blink2

  localparam logic [7:0] BLINK_LAST = 8'(BLINK_TICKS - 1);
  localparam logic [7:0] SEC_LAST = 8'(SEC_TICKS - 1);
  localparam logic [7:0] MIN_LAST = 8'(MIN_SECS - 1);

  logic [7:0] blink_cnt_q;
  logic blink_q;
  logic [7:0] sec_cnt_q;
  logic [7:0] min_cnt_q;

  wire blink_wrap = tick && (blink_cnt_q == BLINK_LAST);
  wire sec_pulse = tick && (sec_cnt_q == SEC_LAST);
  wire min_pulse = sec_pulse && (min_cnt_q == MIN_LAST);

  // Single divider so all blinking LEDs stay in phase
  always_ff @(posedge i_core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      blink_cnt_q <= 8'h00;
      blink_q <= 1'b0;
      sec_cnt_q <= 8'h00;
      min_cnt_q <= 8'h00;
    end
    else
    begin
      if (tick)
        blink_cnt_q <= wrap_inc(blink_cnt_q, BLINK_LAST);
      if (blink_wrap)
        blink_q <= ~blink_q;
      if (tick)
        sec_cnt_q <= wrap_inc(sec_cnt_q, SEC_LAST);
      if (sec_pulse)
        min_cnt_q <= wrap_inc(min_cnt_q, MIN_LAST);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Thermal trip and power failure latches

  logic trip_q;
  logic pf_q;
  wire is_g3 = (i_acpi_state == ACPI_G3);
  wire is_s5 = (i_acpi_state == ACPI_S5);
  wire is_s0 = (i_acpi_state == ACPI_S0);

  always_ff @(posedge i_core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      trip_q <= 1'b0;
      pf_q <= 1'b0;
    end
    else
    begin
      // New trip wins over leaving soft off
      if (i_cpu_crit)
        trip_q <= 1'b1;
      else if (!is_s5 && !o_force_soft_off)
        trip_q <= 1'b0;
      // Only removing supply (reset) clears it
      if (i_power_fail)
        pf_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Watchdog

  wdt_state_t wdt_q;
  logic [WDT_CNT_W-1:0] wdt_cnt_q;
  logic [4:0] fire_cnt_q;
  localparam logic [4:0] FIRE_LAST = 5'(WDT_RST_CYCLES - 1);

  // Granularity select of the decrement pulse
  wire unit_pulse = (i_wdt.gran == GRAN_1MIN) ? min_pulse :
                    (i_wdt.gran == GRAN_1S) ? sec_pulse : tick;
  wire wdt_expire = (wdt_q == WDT_RUN) && unit_pulse &&
                    (wdt_cnt_q == '0);

  always_ff @(posedge i_core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wdt_q <= WDT_IDLE;
      wdt_cnt_q <= '0;
      fire_cnt_q <= 5'h00;
    end
    else
    begin
      unique case (wdt_q)
        WDT_IDLE:
        begin
          if (i_wdt.enable)
          begin
            wdt_q <= WDT_RUN;
            wdt_cnt_q <= i_wdt.timeout;
          end
        end
        WDT_RUN:
        begin
          if (!i_wdt.enable)
            wdt_q <= WDT_IDLE;
          else if (i_wdt.kick)
            wdt_cnt_q <= i_wdt.timeout;
          else if (wdt_expire)
          begin
            wdt_q <= WDT_FIRE;
            fire_cnt_q <= 5'h00;
          end
          else if (unit_pulse)
            wdt_cnt_q <= wdt_cnt_q - WDT_CNT_W'(1);
        end
        WDT_FIRE:
        begin
          fire_cnt_q <= fire_cnt_q + 5'h01;
          if (fire_cnt_q == FIRE_LAST)
            wdt_q <= WDT_IDLE;
        end
        default:
          wdt_q <= WDT_IDLE;
      endcase
    end
  end

  assign o_wdt_sys_reset = (wdt_q == WDT_FIRE);
  assign o_wdt_remaining = wdt_cnt_q;

  //////////////////////////////////////////////////////////////////////////
  // LED selection

  wire led_t pwr_in_d = i_vin_low ? LED_RED : LED_GREEN;
  wire led_t state_led = is_s0 ? LED_GREEN :
                         is_s5 ? LED_ORANGE : LED_OFF;
  // Trip pattern first, then overheat, then the plain state
  wire led_t pwr_d =
    (trip_q && is_s5) ? blink2(blink_q, LED_ORANGE, LED_RED) :
    (i_cpu_hot && !is_g3) ? blink2(blink_q, LED_GREEN, LED_ORANGE) :
    state_led;
  // Power failure outranks plain reset: it needs an operator
  wire in_reset = i_sys_in_reset || o_wdt_sys_reset;
  wire led_t rst_d = pf_q ? blink2(blink_q, LED_RED, LED_OFF) :
                     in_reset ? LED_RED : LED_OFF;

  led_t pwr_in_q;
  led_t pwr_q;
  led_t rst_q;
  logic force_q;
  led_t [NUM_LAN-1:0] act_q;
  led_t [NUM_LAN-1:0] spd_q;
  led_t [NUM_LAN-1:0] act_d;
  led_t [NUM_LAN-1:0] spd_d;

  for (genvar p = 0; p < NUM_LAN; p++)
  begin : g_lan
    assign act_d[p] = !i_lan[p].link ? LED_OFF :
                      (i_lan[p].act ? blink2(blink_q, LED_GREEN, LED_OFF)
                                    : LED_GREEN);
    assign spd_d[p] = !i_lan[p].link ? LED_OFF :
                      (i_lan[p].speed == SPD_1000) ? LED_ORANGE :
                      (i_lan[p].speed == SPD_100) ? LED_GREEN :
                      LED_OFF;
  end

  always_ff @(posedge i_core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pwr_in_q <= LED_OFF;
      pwr_q <= LED_OFF;
      rst_q <= LED_RED;
      force_q <= 1'b0;
      act_q <= '0;
      spd_q <= '0;
    end
    else
    begin
      pwr_in_q <= pwr_in_d;
      pwr_q <= pwr_d;
      rst_q <= rst_d;
      force_q <= i_cpu_crit;
      act_q <= act_d;
      spd_q <= spd_d;
    end
  end

  assign o_pwr_in_led = pwr_in_q;
  assign o_pwr_led = pwr_q;
  assign o_rst_led = rst_q;
  assign o_force_soft_off = force_q;
  assign o_lan_act_led = act_q;
  assign o_lan_spd_led = spd_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  property p_pwr_in;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    i_vin_low |=> o_pwr_in_led == LED_RED;
  endproperty
  a_pwr_in: assert property (p_pwr_in) else $error("input LED not red");

  property p_g3_dark;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    is_g3 |=> o_pwr_led == LED_OFF;
  endproperty
  a_g3_dark: assert property (p_g3_dark) else $error("G3 LED lit");

  property p_s5_orange;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (is_s5 && !trip_q && !i_cpu_hot) |=> o_pwr_led == LED_ORANGE;
  endproperty
  a_s5_orange: assert property (p_s5_orange) else $error("S5 not orange");

  property p_s0_green;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (is_s0 && !i_cpu_hot && !trip_q) |=> o_pwr_led == LED_GREEN;
  endproperty
  a_s0_green: assert property (p_s0_green) else $error("S0 not green");

  property p_hot;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_cpu_hot && !trip_q && !is_g3) |=>
      o_pwr_led.green && (o_pwr_led.red == $past(blink_q));
  endproperty
  a_hot: assert property (p_hot) else $error("hot blink wrong");

  sequence s_crit;
    i_cpu_crit;
  endsequence
  sequence s_trip_shown;
    o_force_soft_off && trip_q;
  endsequence
  property p_crit;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    s_crit |=> s_trip_shown;
  endproperty
  a_crit: assert property (p_crit) else $error("no forced shutdown");

  property p_trip_blink;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (trip_q && is_s5) |=>
      o_pwr_led.red && (o_pwr_led.green == !$past(blink_q));
  endproperty
  a_trip_blink: assert property (p_trip_blink) else $error("trip blink");

  property p_rst_red;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_sys_in_reset && !pf_q) |=> o_rst_led == LED_RED;
  endproperty
  a_rst_red: assert property (p_rst_red) else $error("reset LED dark");

  property p_pf_hold;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    i_power_fail |=> pf_q [*4];
  endproperty
  a_pf_hold: assert property (p_pf_hold) else $error("fail not held");

  property p_lan;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    !i_lan[0].link |=> (o_lan_act_led[0] == LED_OFF) &&
                       (o_lan_spd_led[0] == LED_OFF);
  endproperty
  a_lan: assert property (p_lan) else $error("LAN LED lit");

  property p_gig;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_lan[0].link && i_lan[0].speed == SPD_1000) |=>
      o_lan_spd_led[0] == LED_ORANGE;
  endproperty
  a_gig: assert property (p_gig) else $error("1G not orange");

  property p_gran;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_wdt.gran == GRAN_1S && unit_pulse) |-> sec_pulse && tick;
  endproperty
  a_gran: assert property (p_gran) else $error("wrong tick");

  property p_fire;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    wdt_expire |=> o_wdt_sys_reset [*8];
  endproperty
  a_fire: assert property (p_fire) else $error("no watchdog reset");

  property p_blink;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (blink_q != $past(blink_q)) |-> $past(blink_wrap);
  endproperty
  a_blink: assert property (p_blink) else $error("blink off divider");

endmodule : status_indicator_and_watchdog

`default_nettype wire

// *** design/status_pkg.sv ***
package status_pkg;

  // Clock and time base
  localparam int unsigned CLK_KHZ = 200_000;
  localparam int unsigned T_TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = T_TICK_MS * CLK_KHZ;
  localparam int unsigned T_BLINK_HALF_MS = 500;
  localparam int unsigned BLINK_TICKS = T_BLINK_HALF_MS / T_TICK_MS;
  localparam int unsigned T_SEC_MS = 1000;
  localparam int unsigned SEC_TICKS = T_SEC_MS / T_TICK_MS;
  localparam int unsigned MIN_SECS = 60;
  localparam int unsigned WDT_RST_CYCLES = 16;
  localparam int unsigned WDT_CNT_W = 8;

  // Platform power state, one-hot as delivered by power management
  localparam logic [2:0] ACPI_G3 = 3'h1;
  localparam logic [2:0] ACPI_S5 = 3'h2;
  localparam logic [2:0] ACPI_S0 = 3'h4;

  // Ethernet link speed codes
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // Watchdog tick granularity codes
  localparam logic [1:0] GRAN_10MS = 2'h0;
  localparam logic [1:0] GRAN_1S = 2'h1;
  localparam logic [1:0] GRAN_1MIN = 2'h2;

  // Two-colour LED: orange is both dice lit
  typedef struct packed {
    logic red;
    logic green;
  } led_t;

  localparam led_t LED_OFF = 2'h0;
  localparam led_t LED_GREEN = 2'h1;
  localparam led_t LED_RED = 2'h2;
  localparam led_t LED_ORANGE = 2'h3;

  // Per-port Ethernet status
  typedef struct packed {
    logic link;
    logic act;
    logic [1:0] speed;
  } lan_t;

  // Watchdog control from software
  typedef struct packed {
    logic enable;
    logic kick;
    logic [1:0] gran;
    logic [WDT_CNT_W-1:0] timeout;
  } wdt_ctl_t;

  typedef enum logic [2:0] {
    WDT_IDLE = 3'h1,
    WDT_RUN = 3'h2,
    WDT_FIRE = 3'h4
  } wdt_state_t;

endpackage : status_pkg

// *** design/tick_gen.sv ***
`timescale 1ns/10ps
`default_nettype none

// Free-running prescaler giving one pulse per base tick
module tick_gen
  import status_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Tick
  output logic o_tick
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic tick_q;
  wire wrap = (cnt_q == LAST);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= wrap ? '0 : cnt_q + CW'(1);
      tick_q <= wrap;
    end
  end

  assign o_tick = tick_q;

endmodule : tick_gen

`default_nettype wire

// *** dv/platform_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Power sequencer: honours a forced shutdown after a short lag
module platform_model
  import status_pkg::*;
#(
  parameter int unsigned SHUT_DLY = 3
) (
  // Clock
  input wire logic i_clk,
  // Bench requests
  input wire logic [2:0] i_req_state,
  input wire logic i_power_on,
  // From design
  input wire logic i_force_off,
  // To design
  output logic [2:0] o_acpi_state
);
  int unsigned wait_q = 0;
  logic off_q = 1'b0;

  // Stays in soft off until powered on again
  always_ff @(posedge i_clk)
  begin
    if (i_force_off && wait_q < SHUT_DLY)
    begin
      wait_q <= wait_q + 1;
    end
    if (i_force_off && wait_q == SHUT_DLY)
    begin
      off_q <= 1'b1;
    end
    if (i_power_on && !i_force_off)
    begin
      off_q <= 1'b0;
      wait_q <= 0;
    end
  end

  assign o_acpi_state = off_q ? ACPI_S5 : i_req_state;
endmodule : platform_model

`default_nettype wire

// *** dv/tb_status_indicator_and_watchdog.sv ***
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end

module tb_status_indicator_and_watchdog;
  import status_pkg::*;
  localparam int TC = 10;
  localparam int HALF = BLINK_TICKS * TC;
  logic clk, rstn, vin_low, hot, crit, sys_rst, pfail, pwr_on;
  logic [2:0] req, acpi;
  lan_t [1:0] lan;
  wdt_ctl_t wdt;
  led_t pwr_in_led, pwr_led, rst_led;
  led_t [1:0] act_led, spd_led;
  logic force_off, wdt_rst;
  logic [WDT_CNT_W-1:0] wdt_rem;
  logic [31:0] seed = 32'h0000FE9B;
  logic [31:0] r;
  int fail_count = 0;
  int tests_run = 0;
  // Board sensor targets the health monitor polls on the management bus
  localparam logic [6:0] SENS_NEAR_INPUT = 7'h48;
  localparam logic [6:0] SENS_CENTRE = 7'h49;

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  status_indicator_and_watchdog #(.TICK_CYC(TC)) i_status_indicator_and_watchdog (
    .i_core_clk(clk), .i_rstn(rstn), .i_vin_low(vin_low),
    .i_acpi_state(acpi), .i_cpu_hot(hot), .i_cpu_crit(crit),
    .i_sys_in_reset(sys_rst), .i_power_fail(pfail), .i_lan(lan),
    .i_wdt(wdt), .o_pwr_in_led(pwr_in_led), .o_pwr_led(pwr_led),
    .o_rst_led(rst_led), .o_lan_act_led(act_led), .o_lan_spd_led(spd_led),
    .o_force_soft_off(force_off), .o_wdt_sys_reset(wdt_rst),
    .o_wdt_remaining(wdt_rem));

  platform_model i_platform_model (
    .i_clk(clk), .i_req_state(req), .i_power_on(pwr_on),
    .i_force_off(force_off), .o_acpi_state(acpi));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic led_t exp_pwr(logic [2:0] s);
    return s == ACPI_S0 ? LED_GREEN : s == ACPI_S5 ? LED_ORANGE : LED_OFF;
  endfunction : exp_pwr

  function automatic led_t exp_spd(lan_t l);
    if (!l.link)
    begin
      return LED_OFF;
    end
    return l.speed == SPD_100 ? LED_GREEN :
           l.speed == SPD_1000 ? LED_ORANGE : LED_OFF;
  endfunction : exp_spd

  function automatic int unit_cyc(logic [1:0] g);
    return g == GRAN_10MS ? TC : g == GRAN_1S ? TC * SEC_TICKS :
           TC * SEC_TICKS * MIN_SECS;
  endfunction : unit_cyc

  function automatic led_t pick(int s);
    return s == 0 ? pwr_led : s == 1 ? rst_led : act_led[0];
  endfunction : pick

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Phase is unknown on entry, so sync to one change first
  task automatic blink(input int s, input led_t a, input led_t b);
    int n;
    led_t v;
    n = 0;
    v = pick(s);
    while (pick(s) === v && n < 2 * HALF)
    begin
      cyc(1);
      n++;
    end
    v = pick(s);
    n = 0;
    while (pick(s) === v && n < 2 * HALF)
    begin
      cyc(1);
      n++;
    end
    `CHK(n, HALF)
    `CHK(v ^ pick(s), a ^ b)
    `CHK(v === a || v === b, 1'b1)
    if (n >= 2 * HALF)
    begin
      fail_count++;
      give_verdict();
    end
  endtask : blink

  task automatic wd_fire(input logic [1:0] g, input logic [7:0] t);
    int n;
    int u;
    u = unit_cyc(g);
    n = 0;
    wdt.gran = g;
    wdt.timeout = t;
    wdt.enable = 1'b1;
    while (wdt_rst !== 1'b1 && n < (t + 2) * u)
    begin
      cyc(1);
      n++;
    end
    `CHK(n >= t * u && n <= (t + 1) * u + 3, 1'b1)
    cyc(2);
    `CHK(rst_led, LED_RED)
    n = 2;
    while (wdt_rst === 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    `CHK(n, WDT_RST_CYCLES)
    wdt.enable = 1'b0;
    cyc(1);
  endtask : wd_fire

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    {vin_low, hot, crit, sys_rst, pfail, pwr_on} = 6'h00;
    req = ACPI_G3;
    lan = 8'h00;
    wdt = '0;
    cyc(20);
    `CHK(rst_led, LED_RED)
    `CHK(pwr_led, LED_OFF)
    `CHK({SENS_NEAR_INPUT, SENS_CENTRE}, 14'h2449)
    rstn = 1'b1;
    cyc(4);
    repeat (200)
    begin
      r = rnd();
      vin_low = r[0];
      req = r[3:1];
      lan = r[11:4] & 8'hBB;
      sys_rst = r[12];
      cyc(1);
      `CHK(pwr_in_led, vin_low ? LED_RED : LED_GREEN)
      `CHK(pwr_led, exp_pwr(req))
      `CHK(rst_led, sys_rst ? LED_RED : LED_OFF)
      for (int i = 0; i < 2; i++)
      begin
        `CHK(act_led[i], lan[i].link ? LED_GREEN : LED_OFF)
        `CHK(spd_led[i], exp_spd(lan[i]))
      end
    end
    sys_rst = 1'b0;
    // Port 0 linked with traffic at 10M, port 1 link down
    lan = 8'h1C;
    // Let the pattern switch settle before syncing to the blink phase
    cyc(4);
    blink(2, LED_GREEN, LED_OFF);
    req = ACPI_S0;
    hot = 1'b1;
    cyc(4);
    blink(0, LED_GREEN, LED_ORANGE);
    crit = 1'b1;
    cyc(1);
    `CHK(force_off, 1'b1)
    // Sequencer lag before soft off shows
    cyc(8);
    blink(0, LED_ORANGE, LED_RED);
    {crit, hot} = 2'h0;
    cyc(2);
    `CHK(force_off, 1'b0)
    blink(0, LED_ORANGE, LED_RED);
    pwr_on = 1'b1;
    cyc(1);
    pwr_on = 1'b0;
    cyc(3);
    `CHK(pwr_led, LED_GREEN)
    wd_fire(GRAN_10MS, 8'h00);
    r = rnd();
    wd_fire(GRAN_10MS, {5'h00, r[2:0]});
    wd_fire(GRAN_1S, 8'h01);
    wdt.timeout = 8'h03;
    wdt.gran = GRAN_10MS;
    wdt.enable = 1'b1;
    repeat (10)
    begin
      cyc(20);
      wdt.kick = 1'b1;
      cyc(1);
      wdt.kick = 1'b0;
      `CHK(wdt_rem, 8'h03)
      `CHK(wdt_rst, 1'b0)
    end
    wdt.enable = 1'b0;
    cyc(1);
    wdt.gran = GRAN_1MIN;
    wdt.timeout = 8'hC8;
    wdt.enable = 1'b1;
    cyc(1500);
    `CHK(wdt_rem, 8'hC8)
    wdt.enable = 1'b0;
    pfail = 1'b1;
    cyc(1);
    pfail = 1'b0;
    cyc(4);
    blink(1, LED_RED, LED_OFF);
    sys_rst = 1'b1;
    blink(1, LED_RED, LED_OFF);
    give_verdict();
  end
endmodule : tb_status_indicator_and_watchdog

`default_nettype wire
